//--- design/acs_seq.sv
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes register port and core result on clk; the event input is asynchronous.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"

// Timing, counted in prescaler ticks of the converter clock:
//   The entry tick is tick 0; the sequencer leaves the wait state on it.
//   The cycle counter reads k during the clocks just before tick k.
//   The sample point is the tick that sees two plus sample length plus extras.
//   The tick that sees the total ends the sample; the next sample starts there.
//   Selections reopen in the converter cycle before that last tick.
// Limitations:
//   A start while the start bit is set is dropped, not queued.
//   Clearing the enable aborts a run and leaves the previous result in place.
//   The 16-bit sum holds 64 full-scale samples, the most that can be asked for.
//   Software must keep the converter clock in range; nothing here checks it.

module acs_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire acs_pkg::acs_bus_req_t bus_req,
  output logic [7:0] rdata_r,
  input wire logic event_in,
  input wire logic [9:0] core_result,
  output acs_pkg::acs_core_ctl_t core_ctl_r,
  output logic irq_r
);
  import acs_pkg::*;

  // Prescaler terminal count: divide by 2, 4, ... 256.
  function automatic logic [7:0] clock_divider_select_limit(input logic [2:0] sel);
    clock_divider_select_limit = (`ACS_CLOCK_DIVIDER_SELECT_BASE << sel) - `ACS_ONE8;
  endfunction : clock_divider_select_limit

  // Register port decode helper.
  function automatic logic hit(input acs_bus_req_t q, input logic [3:0] a);
    hit = (q.addr == a);
  endfunction : hit

  // Software-visible control state.
  logic enable_r;
  logic [2:0] clock_divider_select_r;
  logic [2:0] accnum_r;
  logic [4:0] samplen_r;
  logic [4:0] chan_hold_r;
  logic [1:0] ref_hold_r;
  logic event_start_enable_r;
  logic rdyie_r;
  logic flag_r;
  logic start_conversion_bit_r;
  logic [15:0] res_r;

  // Sequencer state.
  acs_state_t state_r;
  logic [7:0] clock_divider_select_cnt_r;
  logic [6:0] cyc_r;
  logic [6:0] extra_r;
  logic [6:0] smp_cnt_r;
  logic [15:0] acc_r;
  logic [4:0] chan_act_r;
  logic [1:0] ref_act_r;
  logic [4:0] last_chan_r;
  logic first_r;
  logic ev_meta_r;
  logic ev_sync_r;
  logic ev_prev_r;

  // Combinational controls.
  logic tick;
  logic ev_rise;
  logic sw_start;
  logic ev_start;
  logic trig;
  logic [6:0] sh_at;
  logic [6:0] total;
  logic [6:0] nsamples;
  logic at_done;
  logic last_sample;
  logic op_done;
  logic copy_ok;
  logic res_read;
  logic flag_w1c;
  logic [15:0] acc_sum;

  // Event input crosses into clk through two flops; edge is seen on synced copies only.
  // The third flop only keeps the last synced level for the edge detector.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_meta_r <= 1'b0;
      ev_sync_r <= 1'b0;
      ev_prev_r <= 1'b0;
    end else begin
      ev_meta_r <= event_in;
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  // Start conditions; a start while busy is ignored so a running operation is never cut.
  always_comb begin
    ev_rise = ev_sync_r & ~ev_prev_r;
    sw_start = bus_req.wr & hit(bus_req, `ACS_A_COMMAND) & bus_req.wdata[`ACS_B_START_CONVERSION_BIT]
      & enable_r & ~start_conversion_bit_r;
    ev_start = event_start_enable_r & ev_rise & enable_r & ~start_conversion_bit_r;
    trig = sw_start | ev_start;
  end

  // Prescaler: counts only while enabled and restarts on any trigger.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_divider_select_cnt_r <= `ACS_RST_CNT8;
    end else if (!enable_r || trig) begin
      clock_divider_select_cnt_r <= `ACS_RST_CNT8;
    end else if (tick) begin
      clock_divider_select_cnt_r <= `ACS_RST_CNT8;
    end else begin
      clock_divider_select_cnt_r <= clock_divider_select_cnt_r + `ACS_ONE8;
    end
  end

  // Converter clock enable; the start edge of a conversion is one of these ticks.
  // Masking it in the trigger cycle makes the start delay exactly one divider period.
  assign tick = enable_r & ~trig & (clock_divider_select_cnt_r == clock_divider_select_limit(clock_divider_select_r));

  // Conversion length: sampling point and end move out with sample length and extras.
  always_comb begin
    sh_at = `ACS_SH_CYC + {2'h0, samplen_r} + extra_r;
    total = `ACS_NORMAL_CYC + {2'h0, samplen_r} + extra_r;
    nsamples = `ACS_ONE7 << ((accnum_r > `ACS_MAX_ACCNUM) ? `ACS_MAX_ACCNUM : accnum_r);
    at_done = (state_r == ACS_RUN) & tick & (cyc_r == total);
    last_sample = (smp_cnt_r == nsamples - `ACS_ONE7);
    op_done = at_done & last_sample;
    acc_sum = acc_r + {6'h00, core_result};
  end

  // Sequencer walks idle, wait for converter edge, run.
  // The cycle count starts at one on the entry tick, so the end tick is cycle total.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ACS_IDLE;
      cyc_r <= `ACS_RST_CYC;
      smp_cnt_r <= `ACS_RST_ACC;
    end else if (!enable_r) begin
      state_r <= ACS_IDLE;
      cyc_r <= `ACS_RST_CYC;
      smp_cnt_r <= `ACS_RST_ACC;
    end else begin
      case (state_r)
        ACS_IDLE: begin
          if (trig) begin
            state_r <= ACS_WAIT;
          end
        end
        ACS_WAIT: begin
          if (tick) begin
            state_r <= ACS_RUN;
            cyc_r <= `ACS_ONE7;
            smp_cnt_r <= `ACS_RST_ACC;
          end
        end
        ACS_RUN: begin
          if (at_done) begin
            cyc_r <= `ACS_ONE7;
            if (last_sample) begin
              state_r <= ACS_IDLE;
            end else begin
              smp_cnt_r <= smp_cnt_r + `ACS_ONE7;
            end
          end else if (tick) begin
            cyc_r <= cyc_r + `ACS_ONE7;
          end
        end
        default: begin
          state_r <= ACS_IDLE;
        end
      endcase
    end
  end

  // Start-up and channel-change delays are charged to the first sample only.
  // The previous channel survives a disable, so the same input adds no change delay.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      extra_r <= `ACS_RST_CYC;
      first_r <= 1'b1;
      last_chan_r <= `ACS_RST_CHAN;
    end else if (!enable_r) begin
      extra_r <= `ACS_RST_CYC;
      first_r <= 1'b1;
    end else if (state_r == ACS_WAIT && tick) begin
      extra_r <= (first_r ? `ACS_START_EXTRA : `ACS_RST_CYC)
        + ((chan_act_r != last_chan_r) ? `ACS_CHG_EXTRA : `ACS_RST_CYC);
      first_r <= 1'b0;
      last_chan_r <= chan_act_r;
    end else if (at_done) begin
      extra_r <= `ACS_RST_CYC;
    end
  end

  // Accumulator sums samples; the final sum goes to the result with the flag.
  // Clearing it in the wait state means an aborted run leaves no partial sum behind.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= `ACS_RST_RES;
      res_r <= `ACS_RST_RES;
    end else if (state_r == ACS_WAIT) begin
      acc_r <= `ACS_RST_RES;
    end else if (at_done) begin
      if (last_sample) begin
        res_r <= acc_sum;
        acc_r <= `ACS_RST_RES;
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  // Start bit: set by software or event, cleared by hardware as the flag rises.
  // It stays set through every accumulated sample, matching the single flag.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_conversion_bit_r <= 1'b0;
    end else if (!enable_r) begin
      start_conversion_bit_r <= 1'b0;
    end else if (trig) begin
      start_conversion_bit_r <= 1'b1;
    end else if (op_done) begin
      start_conversion_bit_r <= 1'b0;
    end
  end

  // Flag clear sources; reading either result byte counts as a result read.
  always_comb begin
    res_read = bus_req.rd & (hit(bus_req, `ACS_A_RESL) | hit(bus_req, `ACS_A_RESH));
    flag_w1c = bus_req.wr & hit(bus_req, `ACS_A_INTFLAGS) & bus_req.wdata[`ACS_B_RDYFLAG];
  end

  // Result ready flag; completion in the clearing cycle wins so no result is missed.
  // A software clear in that cycle is lost, which is the safer of the two outcomes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (op_done) begin
      flag_r <= 1'b1;
    end else if (res_read || flag_w1c) begin
      flag_r <= 1'b0;
    end
  end

  // Interrupt request follows the flag only when its enable is set.
  // Being a cycle behind the flag, it also drops a cycle after a clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & rdyie_r;
    end
  end

  // Control registers written by software.
  // A read in the cycle after a write already sees the new value.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_r <= 1'b0;
      clock_divider_select_r <= 3'h0;
      accnum_r <= 3'h0;
      samplen_r <= `ACS_RST_CHAN;
      chan_hold_r <= `ACS_RST_CHAN;
      ref_hold_r <= `ACS_RST_REF;
      event_start_enable_r <= 1'b0;
      rdyie_r <= 1'b0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `ACS_A_CTRLA: enable_r <= bus_req.wdata[`ACS_B_ENABLE];
        `ACS_A_CTRLB: accnum_r <= bus_req.wdata[`ACS_F_ACCNUM];
        `ACS_A_CTRLC: begin
          clock_divider_select_r <= bus_req.wdata[`ACS_F_CLOCK_DIVIDER_SELECT];
          ref_hold_r <= bus_req.wdata[`ACS_F_REFERENCE_SELECT];
        end
        `ACS_A_SAMPCTL: samplen_r <= bus_req.wdata[`ACS_F_SAMPLEN];
        `ACS_A_CHSEL: chan_hold_r <= bus_req.wdata[`ACS_F_CHAN];
        `ACS_A_EVCTRL: event_start_enable_r <= bus_req.wdata[`ACS_B_EVENT_START_ENABLE];
        `ACS_A_INTCTRL: rdyie_r <= bus_req.wdata[`ACS_B_RDYIE];
        default: begin
        end
      endcase
    end
  end

  // Active selection copies the holding registers while idle or waiting, or in the final cycle.
  // Nothing is copied while disabled, so selections wait for the enable.
  assign copy_ok = enable_r & ((state_r != ACS_RUN)
    | (last_sample & (cyc_r == total)));

  // A channel written mid-conversion waits here until the copy window opens.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_act_r <= `ACS_RST_CHAN;
      ref_act_r <= `ACS_RST_REF;
    end else if (copy_ok) begin
      chan_act_r <= chan_hold_r;
      ref_act_r <= ref_hold_r;
    end
  end

  // Core control, all registered so the analog side sees glitch-free levels.
  // Tick and sample point share the same delay, so their spacing stays exact.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ctl_r <= '0;
    end else begin
      core_ctl_r.powered <= enable_r;
      core_ctl_r.conv_tick <= tick;
      core_ctl_r.sample_hold <= (state_r == ACS_RUN) & tick & (cyc_r == sh_at);
      core_ctl_r.busy <= (state_r == ACS_RUN);
      core_ctl_r.chan <= chan_act_r;
      core_ctl_r.reference_select <= ref_act_r;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  // Zero elsewhere keeps a shared read bus free of stale bytes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `ACS_RST_BYTE;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `ACS_A_CTRLA: rdata_r <= {7'h00, enable_r};
        `ACS_A_CTRLB: rdata_r <= {5'h00, accnum_r};
        `ACS_A_CTRLC: rdata_r <= {2'h0, ref_hold_r, 1'b0, clock_divider_select_r};
        `ACS_A_SAMPCTL: rdata_r <= {3'h0, samplen_r};
        `ACS_A_CHSEL: rdata_r <= {3'h0, chan_hold_r};
        `ACS_A_COMMAND: rdata_r <= {7'h00, start_conversion_bit_r};
        `ACS_A_EVCTRL: rdata_r <= {7'h00, event_start_enable_r};
        `ACS_A_INTCTRL: rdata_r <= {7'h00, rdyie_r};
        `ACS_A_INTFLAGS: rdata_r <= {7'h00, flag_r};
        `ACS_A_RESL: rdata_r <= res_r[7:0];
        `ACS_A_RESH: rdata_r <= res_r[15:8];
        `ACS_A_STATUS: rdata_r <= {1'b0, ref_act_r, chan_act_r};
        default: rdata_r <= `ACS_RST_BYTE;
      endcase
    end else begin
      rdata_r <= `ACS_RST_BYTE;
    end
  end

endmodule : acs_seq

`default_nettype wire

//--- design/acs_cfg.svh
// Address map, field positions, reset values and timing counts of the conversion sequencer.
// Assumes an 8-bit register port with a 4-bit address; definitions only.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register addresses.
`define ACS_A_CTRLA 4'h0
`define ACS_A_CTRLB 4'h1
`define ACS_A_CTRLC 4'h2
`define ACS_A_SAMPCTL 4'h3
`define ACS_A_CHSEL 4'h4
`define ACS_A_COMMAND 4'h5
`define ACS_A_EVCTRL 4'h6
`define ACS_A_INTCTRL 4'h7
`define ACS_A_INTFLAGS 4'h8
`define ACS_A_RESL 4'h9
`define ACS_A_RESH 4'hA
`define ACS_A_STATUS 4'hB

// Field positions and widths.
`define ACS_B_ENABLE 0
`define ACS_B_START_CONVERSION_BIT 0
`define ACS_B_EVENT_START_ENABLE 0
`define ACS_B_RDYIE 0
`define ACS_B_RDYFLAG 0
`define ACS_F_CLOCK_DIVIDER_SELECT 2:0
`define ACS_F_REFERENCE_SELECT 5:4
`define ACS_F_ACCNUM 2:0
`define ACS_F_SAMPLEN 4:0
`define ACS_F_CHAN 4:0

// Reset values.
`define ACS_RST_BYTE 8'h00
`define ACS_RST_CNT8 8'h00
`define ACS_RST_CYC 7'h00
`define ACS_RST_RES 16'h0000
`define ACS_RST_CHAN 5'h00
`define ACS_RST_REF 2'h0
`define ACS_RST_ACC 7'h00

// Timing counts in converter clock cycles.
`define ACS_NORMAL_CYC 7'h0D
`define ACS_SH_CYC 7'h02
`define ACS_START_EXTRA 7'h01
`define ACS_CHG_EXTRA 7'h01
`define ACS_CLOCK_DIVIDER_SELECT_BASE 8'h02
`define ACS_ONE7 7'h01
`define ACS_ONE8 8'h01
`define ACS_MAX_ACCNUM 3'h6

`endif

//--- design/acs_pkg.sv
// Types shared by the conversion sequencer and whoever instantiates it.
// Assumes acs_cfg.svh for all numeric constants.
package acs_pkg;

  // One register port request, all same-clock signals.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acs_bus_req_t;

  // Control handed to the analog sampling core.
  typedef struct packed {
    logic powered;
    logic conv_tick;
    logic sample_hold;
    logic busy;
    logic [4:0] chan;
    logic [1:0] reference_select;
  } acs_core_ctl_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_WAIT,
    ACS_RUN
  } acs_state_t;

endpackage : acs_pkg

//--- dv/acs_seq_assertions.sv
// Concurrent checks on the conversion sequencer ports, bound into every instance.
// Assumes one clock and the asynchronous active-high reset of the design.
`timescale 1ns/100ps
`default_nettype none
module acs_seq_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire acs_pkg::acs_bus_req_t bus_req,
  input wire logic [7:0] rdata_r,
  input wire acs_pkg::acs_core_ctl_t core_ctl_r
);
  import acs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] tick_n_r;
  logic [7:0] sh_n_r;
  // Ticks and sample points seen while busy; wide enough for 64 long samples.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_n_r <= 12'h000;
      sh_n_r <= 8'h00;
    end else if (!core_ctl_r.busy) begin
      tick_n_r <= 12'h000;
      sh_n_r <= 8'h00;
    end else begin
      tick_n_r <= tick_n_r + {11'h000, core_ctl_r.conv_tick};
      sh_n_r <= sh_n_r + {7'h00, core_ctl_r.sample_hold};
    end
  end
  tick_off_a: assert property (!core_ctl_r.powered [*3] |-> !core_ctl_r.conv_tick)
    else $error("converter tick while disabled");
  tick_pulse_a: assert property (core_ctl_r.conv_tick |=> !core_ctl_r.conv_tick)
    else $error("converter tick longer than one cycle");
  abort_off_a: assert property (!core_ctl_r.powered [*3] |-> !core_ctl_r.busy)
    else $error("busy while disabled");
  busy_power_a: assert property ($rose(core_ctl_r.busy) |-> core_ctl_r.powered)
    else $error("conversion started while disabled");
  sh_busy_a: assert property (core_ctl_r.sample_hold |-> core_ctl_r.busy)
    else $error("sample point outside a conversion");
  sel_freeze_a: assert property (core_ctl_r.sample_hold |->
    $stable(core_ctl_r.chan) && $stable(core_ctl_r.reference_select))
    else $error("selection moved at the sample point");
  conv_len_a: assert property ($fell(core_ctl_r.busy) && core_ctl_r.powered |->
    tick_n_r >= 12'h00D)
    else $error("conversion shorter than thirteen ticks");
  sh_count_a: assert property ($fell(core_ctl_r.busy) && core_ctl_r.powered |->
    sh_n_r >= 8'h01)
    else $error("conversion without a sample point");
  end_tick_a: assert property ($fell(core_ctl_r.busy) && core_ctl_r.powered |->
    core_ctl_r.conv_tick || $past(core_ctl_r.conv_tick))
    else $error("conversion ended away from a tick");
  rd_idle_a: assert property (!$past(bus_req.rd) |-> rdata_r == 8'h00)
    else $error("read data outside the read cycle");
endmodule : acs_seq_chk
bind acs_seq acs_seq_chk i_acs_seq_chk (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
  .rdata_r(rdata_r), .core_ctl_r(core_ctl_r));
`default_nettype wire

//--- dv/acs_core_model.sv
// Stand-in for the analog sampling core behind the sequencer.
// Assumes the sequencer samples core_result only while busy.
`timescale 1ns/100ps
`default_nettype none
module acs_core_model (
  input wire logic clk,
  input wire acs_pkg::acs_core_ctl_t ctl,
  output logic [9:0] core_result
);
  import acs_pkg::*;
  logic [9:0] spin_r = 10'h000;
  // Outside a conversion the value churns, so a late sample never looks right by luck.
  always_ff @(posedge clk) begin
    spin_r <= spin_r + 10'h0ED;
  end
  logic [9:0] held_r = 10'h000;
  // The code is taken from the selections at the sample point, as a real hold would.
  always_ff @(posedge clk) begin
    if (ctl.sample_hold) begin
      held_r <= {ctl.chan, ctl.reference_select, 3'h5};
    end
  end
  // Held code while busy, so a selection reopened late never reaches the result.
  assign core_result = ctl.busy ? held_r : spin_r;
endmodule : acs_core_model
`default_nettype wire

//--- dv/test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer; read results pass through a queue.
// Assumes acs_core_model as analog core; the bench itself is the event source.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
module test_adc_conversion_sequencer;
  import acs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  acs_bus_req_t bus_req = '0;
  logic event_in = 1'b0;
  logic [7:0] rdata_r;
  logic [9:0] core_result;
  acs_core_ctl_t core_ctl_r;
  logic irq_r;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  acs_seq i_acs_seq (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata_r(rdata_r),
    .event_in(event_in), .core_result(core_result), .core_ctl_r(core_ctl_r), .irq_r(irq_r));
  acs_core_model i_acs_core_model (.clk(clk), .ctl(core_ctl_r), .core_result(core_result));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) bad(m);
  endtask : chk
  // One strobe cycle, then one idle cycle so no signal is assigned twice in a step.
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask : rd
  // Bounded wait on busy or the converter tick, sampled after the edge settles.
  task automatic wait_on(input bit tk, input logic v, output int n);
    n = 0;
    #1;
    while ((tk ? core_ctl_r.conv_tick : core_ctl_r.busy) !== v && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000) bad("wait ran out");
  endtask : wait_on
  task automatic conv(output int n);
    bus(`ACS_A_COMMAND, 8'h01, 1'b1);
    rd(`ACS_A_COMMAND, 8'h01);
    // Busy rises only after the prescaler delay, so wait for it before timing the run.
    wait_on(1'b0, 1'b1, n);
    wait_on(1'b0, 1'b0, n);
  endtask : conv
  task automatic res(input logic [15:0] e);
    rd(`ACS_A_INTFLAGS, 8'h01);
    rd(`ACS_A_RESL, e[7:0]);
    rd(`ACS_A_RESH, e[15:8]);
    rd(`ACS_A_INTFLAGS, 8'h00);
    rd(`ACS_A_COMMAND, 8'h00);
  endtask : res
  task automatic rst_chk();
    @(posedge clk);
    #1;
    chk({4'h0, irq_r, core_ctl_r}, 16'h0000, "outputs after reset");
    rd(`ACS_A_COMMAND, 8'h00);
    rd(`ACS_A_INTFLAGS, 8'h00);
  endtask : rst_chk
  function automatic logic [15:0] ev(input logic [4:0] c);
    return {6'h00, c, 2'h1, 3'h5};
  endfunction : ev
  // Read data stands only in the cycle after the strobe, so it is compared there.
  always @(posedge clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) bad("read without a note");
      else chk({8'h00, rdata_r}, {8'h00, exp_q.pop_front()}, "read data");
    end
    rd_d <= bus_req.rd;
  end
  // Watchdog: the sequence needs about a tenth of this span.
  initial begin
    repeat (40000) @(posedge clk);
    bad("watchdog");
    test_done();
  end
  initial begin
    int k;
    int l0;
    int l1;
    int len;
    logic [4:0] ch;
    logic [4:0] sl;
    k = $urandom(32'h43BE);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rst_chk();
    rd(4'hE, 8'h00);
    bus(`ACS_A_CTRLC, 8'h13, 1'b1);
    bus(`ACS_A_CHSEL, 8'h05, 1'b1);
    #1;
    chk({11'h000, core_ctl_r.chan}, 16'h0005 & 16'h0000, "selection before enable");
    bus(`ACS_A_CTRLA, 8'h01, 1'b1);
    // The active copy reaches the core outputs one clock later.
    @(posedge clk);
    #1;
    chk({9'h000, core_ctl_r.reference_select, core_ctl_r.chan}, 16'h0025, "selection copy");
    conv(l1);
    res(ev(5'h05));
    conv(l0);
    res(ev(5'h05));
    // The first run pays start-up and the move off the reset channel.
    chk(16'(l1 - l0), 16'd32, "start-up delay");
    sl = 5'($urandom_range(4, 1));
    bus(`ACS_A_SAMPCTL, {3'h0, sl}, 1'b1);
    conv(len);
    res(ev(5'h05));
    chk(16'(len - l0), 16'(sl * 16), "sample length");
    bus(`ACS_A_SAMPCTL, 8'h00, 1'b1);
    ch = 5'($urandom_range(31, 6));
    bus(`ACS_A_COMMAND, 8'h01, 1'b1);
    repeat (16) @(posedge clk);
    bus(`ACS_A_CHSEL, {3'h0, ch}, 1'b1);
    #1;
    chk({11'h000, core_ctl_r.chan}, 16'h0005, "channel frozen");
    wait_on(1'b0, 1'b0, k);
    res(ev(5'h05));
    conv(len);
    res(ev(ch));
    chk(16'(len - l0), 16'd16, "channel change delay");
    bus(`ACS_A_CTRLB, 8'h01, 1'b1);
    conv(len);
    res(16'(2 * ev(ch)));
    chk(16'(len - l0), 16'd208, "second sample length");
    bus(`ACS_A_CTRLB, 8'h00, 1'b1);
    conv(len);
    chk({15'h0000, irq_r}, 16'h0000, "no request while masked");
    rd(`ACS_A_INTFLAGS, 8'h01);
    bus(`ACS_A_INTCTRL, 8'h01, 1'b1);
    #1;
    chk({15'h0000, irq_r}, 16'h0001, "request when enabled");
    bus(`ACS_A_INTFLAGS, 8'h01, 1'b1);
    rd(`ACS_A_INTFLAGS, 8'h00);
    #1;
    chk({15'h0000, irq_r}, 16'h0000, "request cleared");
    event_in <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0000, core_ctl_r.busy}, 16'h0000, "event ignored when off");
    event_in <= 1'b0;
    bus(`ACS_A_EVCTRL, 8'h01, 1'b1);
    event_in <= 1'b1;
    wait_on(1'b0, 1'b1, k);
    rd(`ACS_A_COMMAND, 8'h01);
    wait_on(1'b0, 1'b0, k);
    rd(`ACS_A_INTFLAGS, 8'h01);
    rd(`ACS_A_COMMAND, 8'h00);
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0000, core_ctl_r.busy}, 16'h0000, "level does not retrigger");
    event_in <= 1'b0;
    bus(`ACS_A_EVCTRL, 8'h00, 1'b1);
    rd(`ACS_A_RESL, 8'(ev(ch)));
    for (int p = 3; p < 6; p++) begin
      bus(`ACS_A_CTRLC, 8'h10 | 8'(p), 1'b1);
      bus(`ACS_A_COMMAND, 8'h01, 1'b1);
      wait_on(1'b1, 1'b1, k);
      @(posedge clk);
      wait_on(1'b1, 1'b1, k);
      chk(16'(k + 1), 16'(2 << p), "tick spacing");
      wait_on(1'b0, 1'b0, k);
      bus(`ACS_A_INTFLAGS, 8'h01, 1'b1);
    end
    bus(`ACS_A_COMMAND, 8'h01, 1'b1);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rst_chk();
    @(posedge clk);
    chk(16'(exp_q.size()), 16'h0000, "reads left over");
    test_done();
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
